// [mqxc_pkg.sv]
package mqxc_pkg;
  // ----------------------------------------
  // address layout
  // ----------------------------------------
  localparam int QADDR_W = 5;
  localparam int DEV_W = 3;
  localparam int QSEL_W = 2;
  localparam int QUEUES = 4;
  localparam int DATA_W = 18;
  localparam int APB_AW = 12;
  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [APB_AW-1:0] STATUS_OFS = 12'h000;
  localparam logic [APB_AW-1:0] CONTROL_OFS = 12'h004;
  localparam int ST_DEVNUM_LSB = 0;
  localparam int ST_NINE_BIT = 3;
  localparam int ST_PRIMARY_BIT = 4;
  localparam int ST_POLLED_BIT = 5;
  localparam int ST_DONE_BIT = 6;
  localparam int ST_RDOWN_BIT = 7;
  localparam int ST_WRHIT_BIT = 8;
  localparam int ST_FLAGOWN_BIT = 9;
  localparam int ST_NULLQ_BIT = 10;
  localparam int CT_DONE_BIT = 0;
  localparam logic [31:0] CONTROL_RST = 32'h0000_0000;
  // ----------------------------------------
  // master reset sequencer
  // ----------------------------------------
  typedef enum logic [1:0] {
    MQXC_IDLE = 2'b00,
    MQXC_IN_RESET = 2'b01,
    MQXC_RUN = 2'b10
  } mqxc_mrs_t;
endpackage : mqxc_pkg

// [mqxc_top.sv]
// The APB slave port and the address map were decided locally.
`timescale 1ns/1ps

// ----------------------------------------
// two-flop synchroniser
// ----------------------------------------
module mqxc_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // data
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      meta_q <= '0;
      dout <= '0;
    end
    else
    begin
      meta_q <= din;
      dout <= meta_q;
    end
  end
endmodule : mqxc_sync

module mqxc_top
  import mqxc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [mqxc_pkg::APB_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // straps and master reset pins
  input wire logic masterResetN,
  input wire logic [mqxc_pkg::DEV_W-1:0] deviceNumberPins,
  input wire logic inputWidthSelect,
  input wire logic primarySelect,
  input wire logic flagModeSelect,
  // write port selection
  input wire logic [mqxc_pkg::QADDR_W-1:0] writeQueueAddress,
  input wire logic writeAddressEnable,
  input wire logic flagStrobe,
  // read port selection
  input wire logic [mqxc_pkg::QADDR_W-1:0] readQueueAddress,
  input wire logic readAddressEnableStrobe,
  input wire logic nullQueueSelect,
  input wire logic outputEnableN,
  // flag token chain
  input wire logic flagTokenIn,
  output logic flagTokenOut,
  output logic flagPollSync,
  // core side
  input wire logic [mqxc_pkg::QUEUES-1:0] queueStatus,
  input wire logic [mqxc_pkg::DATA_W-1:0] readDataIn,
  // shared outputs
  output logic [mqxc_pkg::QUEUES-1:0] almostFullFlagBus,
  output logic almostFullFlagBusOeN,
  output logic [mqxc_pkg::DATA_W-1:0] readData,
  output logic readDataOeN,
  // selection results
  output logic writeSelHit,
  output logic [mqxc_pkg::QSEL_W-1:0] writeQueueSel,
  output logic readSelHit,
  output logic [mqxc_pkg::QSEL_W-1:0] readQueueSel,
  output logic nullQueueActive,
  output logic busWidthNine
);
  import mqxc_pkg::*;

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  localparam int PIN_W = QADDR_W * 2 + DEV_W + 10;
  logic [PIN_W-1:0] pinRaw;
  logic [PIN_W-1:0] pinSync;
  logic mrsN;
  logic mrsActive;
  logic [DEV_W-1:0] numPins;
  logic widthPin;
  logic primaryPin;
  logic modePin;
  logic [QADDR_W-1:0] wAddr;
  logic wEn;
  logic fStrobe;
  logic [QADDR_W-1:0] rAddr;
  logic rEn;
  logic nullSel;
  logic oeN;
  logic tokenIn;

  // master reset synced as active high so the flop reset value means idle
  assign pinRaw = {~masterResetN, deviceNumberPins, inputWidthSelect, primarySelect,
                   flagModeSelect, writeQueueAddress, writeAddressEnable, flagStrobe,
                   readQueueAddress, readAddressEnableStrobe, nullQueueSelect,
                   outputEnableN, flagTokenIn};
  assign {mrsActive, numPins, widthPin, primaryPin, modePin, wAddr, wEn, fStrobe,
          rAddr, rEn, nullSel, oeN, tokenIn} = pinSync;
  assign mrsN = !mrsActive;

  mqxc_sync #(.WIDTH(PIN_W)) u_pin_sync (
    .clk(clk),
    .rst(rst),
    .din(pinRaw),
    .dout(pinSync)
  );

  // ----------------------------------------
  // master reset sequencer and strap capture
  // ----------------------------------------
  mqxc_mrs_t mrsState_q;
  logic [DEV_W-1:0] devNum_q;
  logic nine_q;
  logic primary_q;
  logic polled_q;
  logic running;
  logic released;

  assign running = (mrsState_q == MQXC_RUN);
  assign released = (mrsState_q == MQXC_IN_RESET) && mrsN;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      mrsState_q <= MQXC_IDLE;
    else
    begin
      case (mrsState_q)
        MQXC_IDLE: if (!mrsN) mrsState_q <= MQXC_IN_RESET;
        MQXC_IN_RESET: if (mrsN) mrsState_q <= MQXC_RUN;
        MQXC_RUN: if (!mrsN) mrsState_q <= MQXC_IN_RESET;
        default: mrsState_q <= MQXC_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      devNum_q <= '0;
      nine_q <= 1'b0;
      primary_q <= 1'b0;
      polled_q <= 1'b0;
    end
    else if (!mrsN)
    begin
      devNum_q <= numPins;
      nine_q <= widthPin;
      primary_q <= primaryPin;
      polled_q <= modePin;
    end
  end

  // ----------------------------------------
  // apb registers
  // ----------------------------------------
  logic configDone_q;
  logic [31:0] statusWord;
  logic setupPhase;
  logic accessDone;
  logic mapped;

  assign setupPhase = psel && !penable;
  assign accessDone = psel && penable && pready;
  assign mapped = (paddr == STATUS_OFS) || (paddr == CONTROL_OFS);

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      configDone_q <= CONTROL_RST[CT_DONE_BIT];
    else if (!running)
      configDone_q <= CONTROL_RST[CT_DONE_BIT];
    else if (accessDone && pwrite && (paddr == CONTROL_OFS))
      configDone_q <= pwdata[CT_DONE_BIT];
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end
    else if (setupPhase)
    begin
      pready <= 1'b1;
      pslverr <= !mapped;
      if (!pwrite && paddr == STATUS_OFS)
        prdata <= statusWord;
      else if (!pwrite && paddr == CONTROL_OFS)
        prdata <= {31'h0000_0000, configDone_q};
      else
        prdata <= '0;
    end
    else if (accessDone)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // ----------------------------------------
  // queue address decode
  // ----------------------------------------
  logic wrMatch;
  logic rdMatch;
  logic wrSelect;
  logic rdSelect;

  assign wrMatch = (wAddr[QADDR_W-1:QSEL_W] == devNum_q);
  assign rdMatch = (rAddr[QADDR_W-1:QSEL_W] == devNum_q);
  assign wrSelect = running && configDone_q && wEn;
  assign rdSelect = running && configDone_q && rEn;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      writeSelHit <= 1'b0;
      writeQueueSel <= '0;
    end
    else if (!running)
      writeSelHit <= 1'b0;
    else if (wrSelect)
    begin
      writeSelHit <= wrMatch;
      writeQueueSel <= wAddr[QSEL_W-1:0];
    end
  end

  logic readOwner_q;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      readOwner_q <= 1'b0;
      readSelHit <= 1'b0;
      readQueueSel <= '0;
      nullQueueActive <= 1'b0;
    end
    else if (!running)
    begin
      readOwner_q <= 1'b0;
      readSelHit <= 1'b0;
      nullQueueActive <= 1'b0;
    end
    else if (released)
      readOwner_q <= primary_q;
    else if (rdSelect)
    begin
      readOwner_q <= rdMatch;
      readSelHit <= rdMatch && !nullSel;
      readQueueSel <= rAddr[QSEL_W-1:0];
      nullQueueActive <= rdMatch && nullSel;
    end
  end

  // ----------------------------------------
  // read data path
  // ----------------------------------------
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      readData <= '0;
      readDataOeN <= 1'b1;
    end
    else
    begin
      readData <= readDataIn;
      readDataOeN <= !(running && readOwner_q && !oeN);
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      busWidthNine <= 1'b0;
    else
      busWidthNine <= nine_q;
  end

  // ----------------------------------------
  // flag bus: polled token chain and direct select
  // ----------------------------------------
  logic injected_q;
  logic flagOwner_q;
  logic pollNow;

  assign pollNow = running && configDone_q && polled_q &&
                   (tokenIn || (primary_q && !injected_q));

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      injected_q <= 1'b0;
    else if (!running)
      injected_q <= 1'b0;
    else if (pollNow)
      injected_q <= 1'b1;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      flagOwner_q <= 1'b0;
    else if (!running || polled_q)
      flagOwner_q <= 1'b0;
    else if (configDone_q && fStrobe)
      flagOwner_q <= wrMatch;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      almostFullFlagBus <= '0;
      almostFullFlagBusOeN <= 1'b1;
      flagTokenOut <= 1'b0;
      flagPollSync <= 1'b0;
    end
    else
    begin
      almostFullFlagBus <= queueStatus;
      almostFullFlagBusOeN <= polled_q ? !pollNow : !flagOwner_q;
      flagTokenOut <= pollNow;
      flagPollSync <= pollNow;
    end
  end

  assign statusWord = {21'h00_0000, nullQueueActive, flagOwner_q, writeSelHit,
                       readOwner_q, configDone_q, polled_q, primary_q, nine_q,
                       devNum_q};

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  a_token_pulse: assert property (@(posedge clk) disable iff (rst)
    flagTokenOut |-> !almostFullFlagBusOeN && flagPollSync)
    else $error("token out without own status on flag bus");

  a_token_load: assert property (@(posedge clk) disable iff (rst)
    (running && configDone_q && polled_q && tokenIn && $stable(running))
      |=> flagTokenOut && almostFullFlagBus == $past(queueStatus))
    else $error("token in did not load status next edge");

  a_sync_slot: assert property (@(posedge clk) disable iff (rst)
    polled_q && running |-> (flagPollSync == !almostFullFlagBusOeN))
    else $error("poll sync not matching flag bus slot");

  a_wr_match: assert property (@(posedge clk) disable iff (rst)
    (wrSelect && wrMatch && running) |=> writeSelHit)
    else $error("write match not reported");

  a_rd_nomatch: assert property (@(posedge clk) disable iff (rst)
    (rdSelect && !rdMatch && !released) |=> ##1 readDataOeN)
    else $error("unselected device still drives read data");

  a_strap_hold: assert property (@(posedge clk) disable iff (rst)
    running && $past(running) |-> $stable(devNum_q) && $stable(primary_q))
    else $error("straps changed outside master reset");

  a_oe_master: assert property (@(posedge clk) disable iff (rst)
    (running && readOwner_q && oeN) |=> readDataOeN)
    else $error("read data driven with output enable high");

  a_slave_float: assert property (@(posedge clk) disable iff (rst)
    released && !primary_q |=> !readOwner_q ##1 readDataOeN)
    else $error("slave drives read data after reset");

  a_null_q: assert property (@(posedge clk) disable iff (rst)
    nullQueueActive |-> !readSelHit)
    else $error("null queue and real queue both selected");

  a_mrs_seq: assert property (@(posedge clk) disable iff (rst)
    (mrsState_q == MQXC_IDLE) |-> !configDone_q && readDataOeN)
    else $error("device active before first master reset");
endmodule : mqxc_top

// [mqxc_host.sv]
`timescale 1ns/1ps

// --------
// host pins
// --------
module mqxc_host
  import mqxc_pkg::*;
(
  // clock
  input wire logic clk,
  // straps
  output logic masterResetN,
  output logic [mqxc_pkg::DEV_W-1:0] deviceNumberPins,
  output logic inputWidthSelect,
  output logic primarySelect,
  output logic flagModeSelect,
  // selection
  output logic [mqxc_pkg::QADDR_W-1:0] writeQueueAddress,
  output logic writeAddressEnable,
  output logic flagStrobe,
  output logic [mqxc_pkg::QADDR_W-1:0] readQueueAddress,
  output logic readAddressEnableStrobe,
  output logic nullQueueSelect,
  output logic outputEnableN,
  // token
  input wire logic flagTokenOut,
  output logic flagTokenIn
);
  logic loopTok;
  // lone device feeds its token back
  assign flagTokenIn = loopTok & flagTokenOut;
  initial
  begin
    loopTok = 1'b0;
    masterResetN = 1'b1;
    deviceNumberPins = '0;
    inputWidthSelect = 1'b0;
    primarySelect = 1'b1;
    flagModeSelect = 1'b0;
    writeQueueAddress = '0;
    writeAddressEnable = 1'b0;
    flagStrobe = 1'b0;
    readQueueAddress = '0;
    readAddressEnableStrobe = 1'b0;
    nullQueueSelect = 1'b0;
    outputEnableN = 1'b0;
  end
  // straps settle first, stay put after
  task automatic masterReset(input logic [DEV_W-1:0] n, input logic w, input logic p,
    input logic f, input logic l);
    @(posedge clk);
    deviceNumberPins <= n;
    inputWidthSelect <= w;
    primarySelect <= p;
    flagModeSelect <= f;
    loopTok <= l;
    repeat (2) @(posedge clk);
    masterResetN <= 1'b0;
    repeat (4) @(posedge clk);
    masterResetN <= 1'b1;
    repeat (5) @(posedge clk);
  endtask : masterReset
  task automatic selectQueue(input logic r, input logic [QADDR_W-1:0] ad, input logic nq);
    @(posedge clk);
    if (r)
    begin
      readQueueAddress <= ad;
      readAddressEnableStrobe <= 1'b1;
      nullQueueSelect <= nq;
    end
    else
    begin
      writeQueueAddress <= ad;
      writeAddressEnable <= 1'b1;
      flagStrobe <= 1'b1;
    end
    @(posedge clk);
    readAddressEnableStrobe <= 1'b0;
    nullQueueSelect <= 1'b0;
    writeAddressEnable <= 1'b0;
    flagStrobe <= 1'b0;
    repeat (4) @(posedge clk);
  endtask : selectQueue
  task automatic setOe(input logic v);
    @(posedge clk);
    outputEnableN <= v;
    repeat (4) @(posedge clk);
  endtask : setOe
endmodule : mqxc_host

// [mqxc_top_bench.sv]
`timescale 1ns/1ps

module mqxc_top_bench;
  import mqxc_pkg::*;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, err, iw, hit, mon;
  logic [APB_AW-1:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic masterResetN, inputWidthSelect, primarySelect, flagModeSelect;
  logic [DEV_W-1:0] deviceNumberPins, num;
  logic [QADDR_W-1:0] writeQueueAddress, readQueueAddress, a;
  logic writeAddressEnable, flagStrobe, readAddressEnableStrobe, nullQueueSelect;
  logic outputEnableN, flagTokenIn, flagTokenOut, flagPollSync, almostFullFlagBusOeN;
  logic [QUEUES-1:0] queueStatus, qsPrev, almostFullFlagBus;
  logic [DATA_W-1:0] readDataIn, rdPrev, readData;
  logic readDataOeN, writeSelHit, readSelHit, nullQueueActive, busWidthNine;
  logic [QSEL_W-1:0] writeQueueSel, readQueueSel;
  int miscompares, numChecks, pulses, last;

  mqxc_top u_dut (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .masterResetN, .deviceNumberPins, .inputWidthSelect, .primarySelect,
    .flagModeSelect, .writeQueueAddress, .writeAddressEnable, .flagStrobe, .readQueueAddress,
    .readAddressEnableStrobe, .nullQueueSelect, .outputEnableN, .flagTokenIn, .flagTokenOut,
    .flagPollSync, .queueStatus, .readDataIn, .almostFullFlagBus, .almostFullFlagBusOeN,
    .readData, .readDataOeN, .writeSelHit, .writeQueueSel, .readSelHit, .readQueueSel,
    .nullQueueActive, .busWidthNine);
  mqxc_host u_host (.clk, .masterResetN, .deviceNumberPins, .inputWidthSelect,
    .primarySelect, .flagModeSelect, .writeQueueAddress, .writeAddressEnable, .flagStrobe,
    .readQueueAddress, .readAddressEnableStrobe, .nullQueueSelect, .outputEnableN,
    .flagTokenOut, .flagTokenIn);

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk)
  begin
    queueStatus <= QUEUES'($urandom);
    readDataIn <= DATA_W'($urandom);
    qsPrev <= queueStatus;
    rdPrev <= readDataIn;
  end
  // --------
  // checking
  // --------
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    numChecks++;
    if (g !== e)
    begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask : chk
  function automatic logic [31:0] expSt(input logic [2:0] n, input logic w, input logic p,
    input logic f, input logic d);
    expSt = {25'h0, d, f, p, w, n};
  endfunction : expSt
  always @(negedge clk)
    if (mon)
    begin
      if (!almostFullFlagBusOeN)
        chk("flagBus", qsPrev, almostFullFlagBus);
      if (!readDataOeN)
        chk("readData", rdPrev, readData);
      chk("pollSync", flagTokenOut, flagPollSync);
      if (flagPollSync)
        chk("syncOeN", 0, almostFullFlagBusOeN);
    end
  task automatic summarize();
    $display("checks %0d mismatches %0d", numChecks, miscompares);
    if (miscompares == 0 && numChecks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : summarize
  // --------
  // stimulus
  // --------
  task automatic apb(input logic w, input logic [APB_AW-1:0] ad, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (n >= 20)
    begin
      miscompares++;
      summarize();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic cfg(input logic p, input logic f, input logic l);
    num = DEV_W'($urandom);
    iw = 1'($urandom);
    u_host.masterReset(num, iw, p, f, l);
    apb(1'b0, STATUS_OFS, '0);
    chk("status", expSt(num, iw, p, f, 1'b0), rd & 32'h7f);
    chk("busWidthNine", iw, busWidthNine);
    apb(1'b1, CONTROL_OFS, 32'h1);
    apb(1'b0, CONTROL_OFS, '0);
    chk("control", 32'h1, rd);
  endtask : cfg
  task automatic pick(input logic m);
    a = QADDR_W'($urandom);
    a[4:2] = m ? num : num + 3'h1;
    hit = m;
  endtask : pick
  task automatic rdSel(input logic m, input logic nq);
    pick(m);
    u_host.selectQueue(1'b1, a, nq);
  endtask : rdSel
  initial
  begin
    {rst, mon} = 2'b10;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {queueStatus, readDataIn, miscompares, numChecks} = '0;
    void'($urandom(32'h87d9));
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk("readDataOeN", 1, readDataOeN);
    chk("flagOeN", 1, almostFullFlagBusOeN);
    mon = 1'b1;
    cfg(1'b1, 1'b0, 1'b0);
    apb(1'b0, 12'h008, '0);
    chk("slvErr", 1, err);
    chk("unmapped", 0, rd);
    apb(1'b1, STATUS_OFS, 32'hffff_ffff);
    apb(1'b0, STATUS_OFS, '0);
    chk("statusRo", expSt(num, iw, 1'b1, 1'b0, 1'b1), rd & 32'h7f);
    $display("test config done");
    for (int i = 0; i < 10; i++)
    begin
      pick(1'($urandom));
      u_host.selectQueue(1'b0, a, 1'b0);
      chk("writeSelHit", hit, writeSelHit);
      if (hit)
        chk("writeQueueSel", a[1:0], writeQueueSel);
      chk("flagOeN", !hit, almostFullFlagBusOeN);
      rdSel(1'($urandom), 1'b0);
      chk("readSelHit", hit, readSelHit);
      if (hit)
        chk("readQueueSel", a[1:0], readQueueSel);
      chk("readDataOeN", !hit, readDataOeN);
    end
    rdSel(1'b1, 1'b1);
    chk("nullActive", 1, nullQueueActive);
    chk("nullSelHit", 0, readSelHit);
    chk("nullOeN", 0, readDataOeN);
    u_host.setOe(1'b1);
    chk("oeHigh", 1, readDataOeN);
    u_host.setOe(1'b0);
    chk("oeLow", 0, readDataOeN);
    rdSel(1'b0, 1'b1);
    chk("nullMiss", 0, nullQueueActive);
    $display("test select done");
    cfg(1'b0, 1'b0, 1'b0);
    chk("slaveOeN", 1, readDataOeN);
    rdSel(1'b0, 1'b0);
    chk("slaveMiss", 1, readDataOeN);
    rdSel(1'b1, 1'b0);
    chk("slaveHit", 0, readDataOeN);
    $display("test slave done");
    cfg(1'b1, 1'b1, 1'b1);
    {pulses, last} = '0;
    for (int c = 1; c <= 60; c++)
    begin
      @(negedge clk);
      if (flagTokenOut === 1'b1)
      begin
        if (pulses > 0)
          chk("tokenGap", 3, c - last);
        pulses++;
        last = c;
      end
    end
    chk("tokenRuns", 1, pulses > 10);
    $display("test polled done");
    summarize();
  end
endmodule : mqxc_top_bench
